// [rtl/ptc_pkg.sv]
// Constants, register map and mode codes of the trigger compare block.
// Assumes a 32-bit Avalon-MM slave with byte addresses and one word a register.
package ptc_pkg;

   localparam int unsigned ADDR_W = 5;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned CMP_W = 16;

   // Byte offsets
   localparam logic [ADDR_W-1:0] OFS_CMP_TWO = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_CMP_THREE = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_TRG_CTRL = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_STAGE_VIEW = 5'h0c;
   localparam logic [ADDR_W-1:0] OFS_STATE_VIEW = 5'h10;

   // Trigger control field positions
   localparam int unsigned POS_MODE2 = 8;
   localparam int unsigned POS_ASYNC2 = 11;
   localparam int unsigned POS_MODE3 = 12;
   localparam int unsigned POS_ASYNC3 = 15;

   // State view field positions
   localparam int unsigned POS_FIRST = 0;
   localparam int unsigned POS_EN_SEEN = 1;
   localparam int unsigned POS_TRIG = 2;

   // Reset values
   localparam logic [CMP_W-1:0] RST_CMP = 16'h0000;
   localparam logic RST_ASYNC = 1'b0;
   localparam logic [DATA_W-1:0] RD_ZERO = 32'h00000000;

   // Counter value marking the carrier bottom
   localparam logic [CMP_W-1:0] CNT_BOTTOM = 16'h0001;
   // Compare value whose first carrier cycle is skipped
   localparam logic [CMP_W-1:0] CMP_FIRST_SKIP = 16'h0001;

   typedef enum logic [2:0] {
      MD_OFF = 3'b000,
      MD_DOWN = 3'b001,
      MD_UP = 3'b010,
      MD_UPDOWN = 3'b011,
      MD_PEAK = 3'b100,
      MD_BOTTOM = 3'b101,
      MD_PEAKBOT = 3'b110,
      MD_OFF2 = 3'b111
   } ptc_mode_t;

   localparam ptc_mode_t RST_MODE = MD_OFF;

endpackage : ptc_pkg

// [rtl/ptc_stage.sv]
// Second-stage compare buffer of one trigger channel.
// Assumes write strobe and data on the same clock as the top; counter from the PWM unit.
`timescale 1ns/1ps
module ptc_stage #(
   parameter int unsigned W = ptc_pkg::CMP_W
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire ptc_pkg::ptc_mode_t mode,
   input wire logic buffer_async_update,
   input wire logic wr_stb,
   input wire logic [W-1:0] wr_data,
   input wire logic [W-1:0] first_stage,
   input wire logic [W-1:0] pwm_count,
   input wire logic [W-1:0] pwm_period,
   output logic [W-1:0] compare_second_stage
);
   import ptc_pkg::*;

   typedef struct packed {
      logic [W-1:0] stage;
   } ptc_stage_st_t;

   ptc_stage_st_t st_reg;
   ptc_stage_st_t st_next;
   logic at_peak;
   logic at_bottom;

   initial begin
      if (W < 2 || W > 16) begin
         $error("ptc_stage width out of range");
      end
   end

   assign at_peak = (pwm_count == pwm_period);
   assign at_bottom = (pwm_count == W'(CNT_BOTTOM));

   always_comb begin
      st_next = st_reg;
      if (wr_stb && buffer_async_update) begin
         st_next.stage = wr_data;
      end else begin
         unique case (mode)
            MD_DOWN: begin
               if (at_peak) begin
                  st_next.stage = first_stage;
               end
            end
            MD_UP: begin
               if (at_bottom) begin
                  st_next.stage = first_stage;
               end
            end
            MD_UPDOWN: begin
               if (at_peak || at_bottom) begin
                  st_next.stage = first_stage;
               end
            end
            MD_OFF: begin
               st_next.stage = wr_stb ? wr_data : first_stage;
            end
            MD_PEAKBOT: begin
               st_next.stage = wr_stb ? wr_data : first_stage;
            end
            MD_PEAK, MD_BOTTOM, MD_OFF2: begin
               st_next.stage = wr_stb ? wr_data : first_stage;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st_reg <= '{stage: W'(RST_CMP)};
      end else begin
         st_reg <= st_next;
      end
   end

   assign compare_second_stage = st_reg.stage;

endmodule : ptc_stage

// [rtl/ptc_top.sv]
// Trigger compare channels two and three: register slave, buffers and ADC start triggers.
// Assumes the PWM counter, period, direction and enables come from logic on clk_sys.
`timescale 1ns/1ps
module ptc_top #(
   parameter int unsigned CMP_WIDTH = ptc_pkg::CMP_W
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic [ptc_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [ptc_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [ptc_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [CMP_WIDTH-1:0] pwm_count,
   input wire logic [CMP_WIDTH-1:0] pwm_period,
   input wire logic pwm_count_up,
   input wire logic pwm_edge_aligned,
   input wire logic pwm_output_enable,
   output logic [1:0] adc_start_trigger
);
   import ptc_pkg::*;

   localparam int unsigned NCH = 2;

   typedef struct packed {
      logic ack;
      logic [DATA_W-1:0] rdata;
      logic [CMP_WIDTH-1:0] cmp_two;
      logic [CMP_WIDTH-1:0] cmp_three;
      ptc_mode_t mode_two;
      logic async_two;
      ptc_mode_t mode_three;
      logic async_three;
      logic en_seen;
      logic first_cycle;
      logic [NCH-1:0] cond_prev;
      logic [NCH-1:0] trig;
   } ptc_top_st_t;

   ptc_top_st_t st_reg;
   ptc_top_st_t st_next;

   logic req;
   logic take;
   logic [2:0] word_sel;
   logic [CMP_WIDTH-1:0] wr_cmp_two;
   logic [CMP_WIDTH-1:0] wr_cmp_three;
   logic wr_two;
   logic wr_three;
   logic [CMP_WIDTH-1:0] stage_two;
   logic [CMP_WIDTH-1:0] stage_three;
   logic [NCH-1:0] cond_now;
   logic at_peak;
   logic at_bottom;
   logic hit_two;
   logic hit_three;
   logic skip_two;
   logic skip_three;
   logic wr_ctrl;

   // Refuse package settings that the bus decode and field packing cannot serve
   initial begin
      if (CMP_WIDTH != CMP_W || CMP_WIDTH != 16) begin
         $error("ptc_top supports a 16-bit compare width only");
      end
      if (DATA_W != 32) begin
         $error("ptc_top needs a 32-bit data bus with four byte lanes");
      end
      if (ADDR_W != 5) begin
         $error("ptc_top decodes a five-bit byte address");
      end
      if (OFS_CMP_TWO[1:0] != 2'b00 || OFS_CMP_THREE[1:0] != 2'b00 || OFS_TRG_CTRL[1:0] != 2'b00) begin
         $error("register offsets must be word aligned");
      end
      if (OFS_STAGE_VIEW[1:0] != 2'b00 || OFS_STATE_VIEW[1:0] != 2'b00) begin
         $error("view offsets must be word aligned");
      end
      if (OFS_CMP_TWO == OFS_CMP_THREE || OFS_CMP_TWO == OFS_TRG_CTRL || OFS_CMP_THREE == OFS_TRG_CTRL) begin
         $error("writable register offsets overlap");
      end
      if (OFS_STAGE_VIEW == OFS_STATE_VIEW || OFS_STAGE_VIEW == OFS_TRG_CTRL) begin
         $error("stage view offset overlaps another register");
      end
      if (OFS_STAGE_VIEW == OFS_CMP_TWO || OFS_STAGE_VIEW == OFS_CMP_THREE) begin
         $error("stage view offset overlaps a compare register");
      end
      if (OFS_STATE_VIEW == OFS_CMP_TWO || OFS_STATE_VIEW == OFS_CMP_THREE || OFS_STATE_VIEW == OFS_TRG_CTRL) begin
         $error("state view offset overlaps another register");
      end
      if (POS_MODE2 < 8 || POS_ASYNC3 > 15) begin
         $error("control fields must sit in byte lane one");
      end
      if (POS_MODE2 + 3 > POS_ASYNC2 || POS_ASYNC2 >= POS_MODE3 || POS_MODE3 + 3 > POS_ASYNC3) begin
         $error("control fields overlap");
      end
      if (POS_FIRST == POS_EN_SEEN || POS_TRIG <= POS_EN_SEEN || POS_TRIG <= POS_FIRST) begin
         $error("state view fields overlap");
      end
      if (POS_TRIG + NCH > DATA_W) begin
         $error("state view fields exceed the data bus");
      end
      if (CNT_BOTTOM == 16'h0000 || CMP_FIRST_SKIP == 16'h0000) begin
         $error("carrier bottom and skipped compare value must be nonzero");
      end
   end

   // Merge write data into a compare value under byte enables
   function automatic logic [CMP_WIDTH-1:0] merge_cmp(
      input logic [CMP_WIDTH-1:0] old_v,
      input logic [DATA_W-1:0] wdata,
      input logic [3:0] be
   );
      logic [CMP_WIDTH-1:0] v;
      v = old_v;
      if (be[0]) begin
         v[7:0] = wdata[7:0];
      end
      if (be[1]) begin
         v[15:8] = wdata[15:8];
      end
      return v;
   endfunction : merge_cmp

   // Match or carrier event selected by the mode of one channel
   function automatic logic fire_cond(
      input ptc_mode_t md,
      input logic hit,
      input logic up,
      input logic peak,
      input logic bottom,
      input logic edge_al
   );
      logic up_hit;
      logic dn_hit;
      logic r;
      up_hit = hit && (up || edge_al);
      dn_hit = hit && !up && !edge_al;
      r = 1'b0;
      unique case (md)
         MD_OFF, MD_OFF2: begin
            r = 1'b0;
         end
         MD_DOWN: begin
            r = edge_al ? up_hit : dn_hit;
         end
         MD_UP: begin
            r = up_hit;
         end
         MD_UPDOWN: begin
            r = up_hit || dn_hit;
         end
         MD_PEAK: begin
            r = peak;
         end
         MD_BOTTOM: begin
            r = edge_al ? peak : bottom;
         end
         MD_PEAKBOT: begin
            r = edge_al ? peak : (peak || bottom);
         end
      endcase
      return r;
   endfunction : fire_cond

   // Bus request decode
   assign req = avs_read || avs_write;
   assign take = req && st_reg.ack;
   assign word_sel = avs_address[ADDR_W-1:2];
   assign avs_waitrequest = req && !st_reg.ack;
   assign avs_readdata = st_reg.rdata;

   assign wr_two = take && avs_write && (avs_address == OFS_CMP_TWO);
   assign wr_three = take && avs_write && (avs_address == OFS_CMP_THREE);
   assign wr_ctrl = take && avs_write && (avs_address == OFS_TRG_CTRL);
   assign wr_cmp_two = merge_cmp(st_reg.cmp_two, avs_writedata, avs_byteenable);
   assign wr_cmp_three = merge_cmp(st_reg.cmp_three, avs_writedata, avs_byteenable);

   // Carrier events
   assign at_peak = (pwm_count == pwm_period);
   assign at_bottom = (pwm_count == CNT_BOTTOM);

   // Counter against the active second stage of each channel
   assign hit_two = (pwm_count == stage_two);
   assign hit_three = (pwm_count == stage_three);

   // Compare value one held off until the first peak after enable
   assign skip_two = st_reg.first_cycle && (stage_two == CMP_FIRST_SKIP);
   assign skip_three = st_reg.first_cycle && (stage_three == CMP_FIRST_SKIP);

   ptc_stage #(
      .W(CMP_WIDTH)
   ) u_stage_two (
      .clk_sys(clk_sys),
      .srst(srst),
      .mode(st_reg.mode_two),
      .buffer_async_update(st_reg.async_two),
      .wr_stb(wr_two),
      .wr_data(wr_cmp_two),
      .first_stage(st_reg.cmp_two),
      .pwm_count(pwm_count),
      .pwm_period(pwm_period),
      .compare_second_stage(stage_two)
   );

   ptc_stage #(
      .W(CMP_WIDTH)
   ) u_stage_three (
      .clk_sys(clk_sys),
      .srst(srst),
      .mode(st_reg.mode_three),
      .buffer_async_update(st_reg.async_three),
      .wr_stb(wr_three),
      .wr_data(wr_cmp_three),
      .first_stage(st_reg.cmp_three),
      .pwm_count(pwm_count),
      .pwm_period(pwm_period),
      .compare_second_stage(stage_three)
   );

   // Raw trigger conditions per channel
   always_comb begin
      cond_now[0] = fire_cond(st_reg.mode_two, hit_two, pwm_count_up,
         at_peak, at_bottom, pwm_edge_aligned);
      cond_now[1] = fire_cond(st_reg.mode_three, hit_three, pwm_count_up,
         at_peak, at_bottom, pwm_edge_aligned);
      if (skip_two) begin
         cond_now[0] = 1'b0;
      end
      if (skip_three) begin
         cond_now[1] = 1'b0;
      end
      if (!pwm_output_enable) begin
         cond_now = '0;
      end
   end

   always_comb begin
      st_next = st_reg;

      // One wait cycle, then the answer
      st_next.ack = req && !st_reg.ack;

      if (req && !st_reg.ack && avs_read) begin
         unique case (word_sel)
            OFS_CMP_TWO[ADDR_W-1:2]: begin
               st_next.rdata = {16'h0000, st_reg.cmp_two};
            end
            OFS_CMP_THREE[ADDR_W-1:2]: begin
               st_next.rdata = {16'h0000, st_reg.cmp_three};
            end
            OFS_TRG_CTRL[ADDR_W-1:2]: begin
               st_next.rdata = RD_ZERO;
               st_next.rdata[POS_MODE2 +: 3] = st_reg.mode_two;
               st_next.rdata[POS_ASYNC2] = st_reg.async_two;
               st_next.rdata[POS_MODE3 +: 3] = st_reg.mode_three;
               st_next.rdata[POS_ASYNC3] = st_reg.async_three;
            end
            OFS_STAGE_VIEW[ADDR_W-1:2]: begin
               st_next.rdata = {stage_three, stage_two};
            end
            OFS_STATE_VIEW[ADDR_W-1:2]: begin
               st_next.rdata = RD_ZERO;
               st_next.rdata[POS_FIRST] = st_reg.first_cycle;
               st_next.rdata[POS_EN_SEEN] = st_reg.en_seen;
               st_next.rdata[POS_TRIG +: 2] = st_reg.cond_prev;
            end
            default: begin
               st_next.rdata = RD_ZERO;
            end
         endcase
      end

      if (wr_two) begin
         st_next.cmp_two = wr_cmp_two;
      end
      if (wr_three) begin
         st_next.cmp_three = wr_cmp_three;
      end
      if (wr_ctrl) begin
         if (avs_byteenable[1]) begin
            st_next.mode_two = ptc_mode_t'(avs_writedata[POS_MODE2 +: 3]);
            st_next.async_two = avs_writedata[POS_ASYNC2];
            st_next.mode_three = ptc_mode_t'(avs_writedata[POS_MODE3 +: 3]);
            st_next.async_three = avs_writedata[POS_ASYNC3];
         end
      end

      // First carrier cycle after enable ends at the first peak
      st_next.en_seen = pwm_output_enable;
      if (pwm_output_enable && !st_reg.en_seen) begin
         st_next.first_cycle = 1'b1;
      end else if (!pwm_output_enable || at_peak) begin
         st_next.first_cycle = 1'b0;
      end

      // One pulse per match, even when the counter dwells
      st_next.cond_prev = cond_now;
      st_next.trig = cond_now & ~st_reg.cond_prev;
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st_reg <= '{ack: 1'b0, rdata: RD_ZERO, cmp_two: RST_CMP, cmp_three: RST_CMP,
            mode_two: RST_MODE, async_two: RST_ASYNC, mode_three: RST_MODE,
            async_three: RST_ASYNC, en_seen: 1'b0, first_cycle: 1'b0,
            cond_prev: 2'b00, trig: 2'b00};
      end else begin
         st_reg <= st_next;
      end
   end

   assign adc_start_trigger = st_reg.trig;

endmodule : ptc_top

// [verif/ptc_carrier.sv]
// Carrier counter model standing in for the PWM generator.
// Assumes the bench drives run, period and edge-aligned select on clk_sys.
`timescale 1ns/1ps
module ptc_carrier (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic run,
   input wire logic edge_al,
   input wire logic [15:0] period,
   output logic [15:0] pwm_count,
   output logic pwm_count_up
);
   // Stopped carrier parks at zero, which no legal compare value hits
   always_ff @(posedge clk_sys) begin
      if (srst || !run) begin
         pwm_count <= 16'h0000;
         pwm_count_up <= 1'b1;
      end else if (edge_al) begin
         pwm_count <= (pwm_count == period) ? 16'h0001 : pwm_count + 16'h0001;
         pwm_count_up <= 1'b1;
      end else if (pwm_count_up && pwm_count == period) begin
         pwm_count <= pwm_count - 16'h0001;
         pwm_count_up <= 1'b0;
      end else if (!pwm_count_up && pwm_count == 16'h0001) begin
         pwm_count <= 16'h0002;
         pwm_count_up <= 1'b1;
      end else begin
         pwm_count <= pwm_count_up ? pwm_count + 16'h0001 : pwm_count - 16'h0001;
      end
   end
endmodule : ptc_carrier

// [verif/ptc_chk.sv]
// Assertion checker for the trigger compare top, bound below.
// Assumes software writes registers as full words.
`timescale 1ns/1ps
module ptc_chk
   import ptc_pkg::*;
#(
   parameter int unsigned CMP_WIDTH = CMP_W
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [DATA_W-1:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [CMP_WIDTH-1:0] pwm_count,
   input wire logic [CMP_WIDTH-1:0] pwm_period,
   input wire logic pwm_count_up,
   input wire logic pwm_edge_aligned,
   input wire logic pwm_output_enable,
   input wire logic [1:0] adc_start_trigger
);
   logic [7:0] ctrl_reg;
   logic [CMP_WIDTH-1:0] cmp2_reg;
   logic [2:0] mode2;
   logic wr_ok;
   assign wr_ok = avs_write && !avs_waitrequest;
   assign mode2 = ctrl_reg[2:0];
   // Shadow of what software wrote
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ctrl_reg <= 8'h00;
         cmp2_reg <= '0;
      end else if (wr_ok && avs_address == OFS_TRG_CTRL) begin
         ctrl_reg <= avs_writedata[15:8];
      end else if (wr_ok && avs_address == OFS_CMP_TWO) begin
         cmp2_reg <= avs_writedata[CMP_WIDTH-1:0];
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   a_wait_first: assert property (($rose(avs_read) || $rose(avs_write)) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("request not answered after one wait state");
   a_wait_bound: assert property ((avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
      else $error("request left waiting");
   a_read_cmp: assert property (avs_read && !avs_waitrequest && avs_address == OFS_CMP_TWO |->
      avs_readdata == DATA_W'(cmp2_reg)) else $error("compare read differs from written value");
   a_read_ctrl: assert property (avs_read && !avs_waitrequest && avs_address == OFS_TRG_CTRL |->
      avs_readdata == {16'h0000, ctrl_reg, 8'h00}) else $error("control read differs from written value");
   a_no_trig_off: assert property (!pwm_output_enable |=> adc_start_trigger == 2'b00)
      else $error("trigger while output disabled");
   a_trig_single: assert property (adc_start_trigger[0] |=> !adc_start_trigger[0])
      else $error("trigger wider than one cycle");
   a_mode_quiet: assert property ((mode2 == MD_OFF || mode2 == MD_OFF2) |=> !adc_start_trigger[0])
      else $error("trigger in disabled mode");
   a_peak_fire: assert property (mode2 == MD_PEAK && $stable(mode2) && cmp2_reg != 1 && pwm_output_enable
      && pwm_count == pwm_period && $past(pwm_count != pwm_period) |=> adc_start_trigger[0])
      else $error("no trigger at carrier peak");
endmodule : ptc_chk

bind ptc_top ptc_chk #(.CMP_WIDTH(CMP_WIDTH)) u_ptc_chk (
   .clk_sys(clk_sys), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pwm_count(pwm_count),
   .pwm_period(pwm_period), .pwm_count_up(pwm_count_up), .pwm_edge_aligned(pwm_edge_aligned),
   .pwm_output_enable(pwm_output_enable), .adc_start_trigger(adc_start_trigger));

// [verif/tb_ptc_top.sv]
// Testbench for the trigger compare top with a carrier counter model.
// Assumes the carrier model below and a short carrier period.
`timescale 1ns/1ps
module tb_ptc_top;
   import ptc_pkg::*;
   localparam int unsigned P = 8;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic [ADDR_W-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [DATA_W-1:0] avs_writedata = '0;
   logic [DATA_W-1:0] avs_readdata;
   logic avs_waitrequest;
   logic [15:0] pwm_count;
   logic [15:0] pwm_period = 16'(P);
   logic pwm_count_up;
   logic run = 1'b0;
   logic edge_al = 1'b0;
   logic pwm_output_enable = 1'b0;
   logic [1:0] adc_start_trigger;
   logic [DATA_W-1:0] rd;
   int error_cnt = 0;
   int num_checks = 0;
   int pulses2 = 0;
   int pulses3 = 0;
   // Mode, edge-aligned, enable, compare value, pulses in a 30-cycle run
   int tab [13][5] = '{'{0,0,1,3,0}, '{1,0,1,3,2}, '{2,0,1,3,2}, '{3,0,1,3,4}, '{4,0,1,3,2},
      '{5,0,1,3,3}, '{6,0,1,3,5}, '{7,0,1,3,0}, '{3,0,0,3,0}, '{3,0,1,1,2}, '{1,1,1,3,4},
      '{5,1,1,3,3}, '{6,1,1,3,3}};

   always #5 clk_sys = ~clk_sys;

   ptc_top u_ptc_top (.clk_sys(clk_sys), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pwm_count(pwm_count),
      .pwm_period(pwm_period), .pwm_count_up(pwm_count_up), .pwm_edge_aligned(edge_al),
      .pwm_output_enable(pwm_output_enable), .adc_start_trigger(adc_start_trigger));
   ptc_carrier u_ptc_carrier (.clk_sys(clk_sys), .srst(srst), .run(run), .edge_al(edge_al),
      .period(pwm_period), .pwm_count(pwm_count), .pwm_count_up(pwm_count_up));

   always @(posedge clk_sys) begin
      if (adc_start_trigger[0] === 1'b1) pulses2++;
      if (adc_start_trigger[1] === 1'b1) pulses3++;
   end

   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Holds the request until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      logic w;
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      do begin
         @(posedge clk_sys);
         w = avs_waitrequest;
         rd = avs_readdata;
      end while (w !== 1'b0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask : bus

   task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      bus(1'b0, a, '0);
      check(rd, exp);
   endtask : rchk

   task automatic print_verdict;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : print_verdict

   initial begin
      repeat (20000) @(posedge clk_sys);
      error_cnt++;
      print_verdict();
   end

   initial begin
      repeat (6) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      rchk(OFS_CMP_TWO, 32'h00000000);
      rchk(OFS_CMP_THREE, 32'h00000000);
      rchk(OFS_TRG_CTRL, 32'h00000000);
      rchk(5'h14, 32'h00000000);
      bus(1'b1, OFS_CMP_TWO, 32'habcd0003);
      bus(1'b1, OFS_CMP_THREE, 32'h00000005);
      rchk(OFS_CMP_TWO, 32'h00000003);
      rchk(OFS_CMP_THREE, 32'h00000005);
      rchk(OFS_STAGE_VIEW, 32'h00050003);
      // Periodic load waits for the carrier event
      for (int m = 1; m < 4; m++) begin
         bus(1'b1, OFS_TRG_CTRL, 32'(m) << POS_MODE2);
         bus(1'b1, OFS_CMP_TWO, 32'(m + 3));
         rchk(OFS_STAGE_VIEW, 32'h00050000 | 32'(m + 2));
         run <= 1'b1;
         do @(negedge clk_sys); while (pwm_count !== (m == 1 ? 16'(P) : 16'h0001));
         @(posedge clk_sys);
         run <= 1'b0;
         rchk(OFS_STAGE_VIEW, 32'h00050000 | 32'(m + 3));
      end
      bus(1'b1, OFS_TRG_CTRL, 32'h00000900);
      rchk(OFS_TRG_CTRL, 32'h00000900);
      bus(1'b1, OFS_CMP_TWO, 32'h00000007);
      rchk(OFS_STAGE_VIEW, 32'h00050007);
      for (int m = 4; m < 8; m++) begin
         bus(1'b1, OFS_TRG_CTRL, 32'(m) << POS_MODE2);
         bus(1'b1, OFS_CMP_TWO, 32'(m + 4));
         rchk(OFS_STAGE_VIEW, 32'h00050000 | 32'(m + 4));
      end
      // Trigger counts per mode; async load, since the carrier is parked meanwhile
      for (int i = 0; i < 13; i++) begin
         bus(1'b1, OFS_TRG_CTRL, 32'h8800 | (32'(tab[i][0]) << POS_MODE2) | (32'(tab[i][0]) << POS_MODE3));
         bus(1'b1, OFS_CMP_TWO, 32'(tab[i][3]));
         bus(1'b1, OFS_CMP_THREE, 32'(tab[i][3]));
         pulses2 = 0;
         pulses3 = 0;
         edge_al <= tab[i][1][0];
         pwm_output_enable <= tab[i][2][0];
         run <= 1'b1;
         repeat (30) @(posedge clk_sys);
         run <= 1'b0;
         pwm_output_enable <= 1'b0;
         repeat (3) @(posedge clk_sys);
         check(32'(pulses2), 32'(tab[i][4]));
         check(32'(pulses3), 32'(tab[i][4]));
      end
      print_verdict();
   end
endmodule : tb_ptc_top
